//--- dma_chan_pkg.sv
// Overview of operation
// - Source pointer is 32-bit read/write and shows the next source address while running.
// - Pointers and count are not reset and hold their value in standby.
// - Destination pointer is 32-bit read/write, counts, and shows the next destination.
// - Count of one means one transfer; zero means 16,777,216 transfers.
// - Reading the count while running returns the units still outstanding.
// - In 16-byte mode the count drops by one per sixteen-byte block.
// - Count bits 31 to 24 ignore writes and read as zero.
// - Channel control bits reset to zero and hold in standby.
// - Control bits 31 to 21 are reserved and read as zero.
// - Bit 20 selects indirect addressing on channel 3 only; elsewhere reads zero. Here the bit is only stored; no indirect access is made.
// - Bit 19 enables source reload on channel 2 only; elsewhere reads zero. Here the bit is only stored; the source pointer is never reloaded.
// - Bits 6 and 16 to 18 exist on channels 0 and 1 only.
// - Bit 18 sets request-accept output polarity: 0 active low, 1 active high.
// - In dual mode bit 17 puts the acknowledge strobe in read or write cycle.
// - In single address mode the acknowledge strobe is driven in both the read and the write cycle.
// - Transfer-end flag clears only by writing zero after reading one.
// - Bit 16 sets acknowledge strobe polarity: 0 active low, 1 active high.
// - Step modes hold, increment or decrement by unit size; 11 holds.
package dma_chan_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [28:0] REG_AREA_MASK = 29'h1fffff00;
  localparam logic [28:0] REG_AREA_BASE = 29'h04000000;
  localparam logic [3:0]  CH_SLOT_FIRST = 4'h2;
  localparam logic [3:0]  CH_SLOT_LAST  = 4'h5;
  localparam logic [3:0]  OFF_SRC_PTR   = 4'h0;
  localparam logic [3:0]  OFF_DST_PTR   = 4'h4;
  localparam logic [3:0]  OFF_COUNT     = 4'h8;
  localparam logic [3:0]  OFF_CONTROL   = 4'hc;

  // ----------------------------------------------------------------
  // Control register fields and masks
  // ----------------------------------------------------------------
  localparam int BIT_VIA_PTR    = 20;
  localparam int BIT_RELOAD     = 19;
  localparam int BIT_REQ_POL    = 18;
  localparam int BIT_ACK_CYCLE  = 17;
  localparam int BIT_ACK_POL    = 16;
  localparam int POS_DST_STEP   = 14;
  localparam int POS_SRC_STEP   = 12;
  localparam int POS_REQ_SRC    = 8;
  localparam int BIT_REQ_SENSE  = 6;
  localparam int POS_UNIT_SIZE  = 3;
  localparam int BIT_TEND       = 1;
  localparam int BIT_RUN        = 0;
  localparam logic [31:0] CTRL_RESET     = 32'h00000000;
  localparam logic [31:0] CTRL_MASK_ALL  = 32'h0000ff3f;
  localparam logic [31:0] CTRL_MASK_EXT  = 32'h00070040;
  localparam logic [31:0] CTRL_MASK_RLD  = 32'h00080000;
  localparam logic [31:0] CTRL_MASK_VIA  = 32'h00100000;
  localparam logic [23:0] COUNT_ONE      = 24'h000001;

  localparam logic [3:0] REQ_EXT_DUAL  = 4'h0;
  localparam logic [3:0] REQ_EXT_MEM2D = 4'h2;
  localparam logic [3:0] REQ_EXT_D2MEM = 4'h3;
  localparam logic [3:0] REQ_AUTO      = 4'h4;
  localparam logic [1:0] STEP_HOLD     = 2'h0;
  localparam logic [1:0] STEP_INC      = 2'h1;
  localparam logic [1:0] STEP_DEC      = 2'h2;

  localparam int FIFO_WIDTH = 32;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    ENG_IDLE  = 2'b00,
    ENG_READ  = 2'b01,
    ENG_XFER  = 2'b10,
    ENG_WRITE = 2'b11
  } eng_state_type;

  function automatic logic [31:0] ctrl_wmask(input logic [1:0] ch);
    if (ch == 2'd0 || ch == 2'd1) begin
      return CTRL_MASK_ALL | CTRL_MASK_EXT;
    end else if (ch == 2'd2) begin
      return CTRL_MASK_ALL | CTRL_MASK_RLD;
    end else begin
      return CTRL_MASK_ALL | CTRL_MASK_VIA;
    end
  endfunction : ctrl_wmask

  function automatic logic [31:0] unit_bytes(input logic [1:0] size);
    case (size)
      2'h0:    return 32'h00000001;
      2'h1:    return 32'h00000002;
      2'h2:    return 32'h00000004;
      default: return 32'h00000010;
    endcase
  endfunction : unit_bytes

endpackage : dma_chan_pkg

//--- ptr_step.sv
`timescale 1ns/1ns
module ptr_step (
  // Pointer and its step settings
  input  wire logic [31:0] i_ptr,
  input  wire logic [1:0]  i_mode,
  input  wire logic [1:0]  i_size,
  // Address for the following unit
  output logic      [31:0] o_next
);
  import dma_chan_pkg::*;

  always_comb begin
    case (i_mode)
      STEP_INC: o_next = i_ptr + unit_bytes(i_size);
      STEP_DEC: o_next = i_ptr - unit_bytes(i_size);
      default:  o_next = i_ptr;
    endcase
  end

endmodule : ptr_step

//--- data_fifo.sv
`timescale 1ns/1ns
module data_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock, reset, enable
  input  wire logic             i_ref_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_clk_en,
  // Filling side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Draining side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_ff;
  logic [PW-1:0]    rd_ptr_ff;
  logic [CW-1:0]    cnt_ff;
  logic             push;
  logic             pop;

  assign o_in_ready  = (cnt_ff != FULL_CNT);
  assign o_out_valid = (cnt_ff != '0);
  assign o_out_data  = mem[rd_ptr_ff];
  assign push        = i_clk_en && i_in_valid && o_in_ready;
  assign pop         = i_clk_en && i_out_ready && o_out_valid;

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= i_in_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
      if (push && !pop) cnt_ff <= cnt_ff + 1'b1;
      else if (pop && !push) cnt_ff <= cnt_ff - 1'b1;
    end
  end

endmodule : data_fifo

//--- dma_chan_regs.sv
`timescale 1ns/1ns
module dma_chan_regs (
  // Clock, reset, clock enable (low enable is standby)
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_clk_en,
  // Register port
  input  wire logic [31:0] i_reg_addr,
  input  wire logic        i_reg_rd,
  input  wire logic        i_reg_wr,
  input  wire logic [3:0]  i_reg_be,
  input  wire logic [31:0] i_reg_wdata,
  output logic      [31:0] o_reg_rdata,
  // Peripheral pins, channels 0 and 1
  input  wire logic [1:0]  i_transfer_request_in_n,
  output logic      [1:0]  o_transfer_ack_strobe,
  output logic      [1:0]  o_request_accept_out,
  // Data bus master
  output logic      [31:0] o_bus_addr,
  output logic             o_bus_rd,
  output logic             o_bus_wr,
  output logic      [1:0]  o_bus_size,
  output logic      [31:0] o_bus_wdata,
  input  wire logic [31:0] i_bus_rdata,
  input  wire logic        i_bus_ack
);
  import dma_chan_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0]   src_ptr_ff [4];
  logic [31:0]   dst_ptr_ff [4];
  logic [23:0]   count_ff   [4];
  logic [31:0]   ctrl_ff    [4];
  logic [3:0]    tend_seen_ff;
  logic [1:0]    req_s1_ff;
  logic [1:0]    req_s2_ff;
  logic [1:0]    req_s3_ff;
  logic [1:0]    req_lvl_ff;
  logic [1:0]    req_edge_ff;
  eng_state_type eng_ff;
  eng_state_type nxt_eng;
  logic [1:0]    act_ch_ff;
  logic [1:0]    nxt_ch;
  logic          area_hit;
  logic          reg_hit;
  logic [1:0]    reg_ch;
  logic [3:0]    reg_off;
  logic          reg_write;
  logic          unit_done;
  logic [3:0]    eligible;
  logic [1:0]    ext_req;
  logic [31:0]   src_next;
  logic [31:0]   dst_next;
  logic          fifo_in_ready;
  logic          fifo_out_valid;
  logic [31:0]   fifo_out_data;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) res[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return res;
  endfunction : be_merge

  function automatic logic is_ext(input logic [3:0] src);
    return src == REQ_EXT_DUAL || src == REQ_EXT_MEM2D || src == REQ_EXT_D2MEM;
  endfunction : is_ext

  function automatic logic is_single(input logic [3:0] src);
    return src == REQ_EXT_MEM2D || src == REQ_EXT_D2MEM;
  endfunction : is_single

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  // The top three address bits are ignored so the cached and uncached
  // views of the area both reach the registers.
  always_comb begin
    area_hit = (i_reg_addr[28:0] & REG_AREA_MASK) == REG_AREA_BASE;
    reg_off  = {i_reg_addr[3:2], 2'b00};
    reg_ch   = 2'(i_reg_addr[7:4] - CH_SLOT_FIRST);
    if (!area_hit) begin
      reg_hit = 1'b0;
    end else if (i_reg_addr[7:4] < CH_SLOT_FIRST) begin
      reg_hit = 1'b0;
    end else if (i_reg_addr[7:4] > CH_SLOT_LAST) begin
      reg_hit = 1'b0;
    end else begin
      reg_hit = 1'b1;
    end
  end

  assign reg_write = i_clk_en && i_reg_wr && reg_hit;
  assign unit_done = i_clk_en && eng_ff == ENG_WRITE && i_bus_ack;

  // ----------------------------------------------------------------
  // Pointers and count
  // ----------------------------------------------------------------
  // No reset here: contents stay undefined until software loads them.
  always_ff @(posedge i_ref_clk) begin
    for (int c = 0; c < 4; c++) begin
      if (reg_write && reg_ch == 2'(c) && reg_off == OFF_SRC_PTR) begin
        src_ptr_ff[c] <= be_merge(src_ptr_ff[c], i_reg_wdata, i_reg_be);
      end else if (unit_done && act_ch_ff == 2'(c)) begin
        src_ptr_ff[c] <= src_next;
      end
      if (reg_write && reg_ch == 2'(c) && reg_off == OFF_DST_PTR) begin
        dst_ptr_ff[c] <= be_merge(dst_ptr_ff[c], i_reg_wdata, i_reg_be);
      end else if (unit_done && act_ch_ff == 2'(c)) begin
        dst_ptr_ff[c] <= dst_next;
      end
      if (reg_write && reg_ch == 2'(c) && reg_off == OFF_COUNT) begin
        count_ff[c] <= 24'(be_merge({8'h00, count_ff[c]}, i_reg_wdata, i_reg_be));
      end else if (unit_done && act_ch_ff == 2'(c)) begin
        count_ff[c] <= count_ff[c] - COUNT_ONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel control and transfer-end flag
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      for (int c = 0; c < 4; c++) ctrl_ff[c] <= CTRL_RESET;
      tend_seen_ff <= 4'h0;
    end else if (i_clk_en) begin
      for (int c = 0; c < 4; c++) begin
        if (reg_write && reg_ch == 2'(c) && reg_off == OFF_CONTROL) begin
          ctrl_ff[c] <= be_merge(ctrl_ff[c], i_reg_wdata, i_reg_be)
                        & ctrl_wmask(2'(c));
          ctrl_ff[c][BIT_TEND] <= ctrl_ff[c][BIT_TEND] &&
                                  !(i_reg_be[0] && !i_reg_wdata[BIT_TEND] &&
                                    tend_seen_ff[c]);
        end
        // The end of the last unit (count of one) sets the flag even when a clear lands together.
        if (unit_done && act_ch_ff == 2'(c) && count_ff[c] == COUNT_ONE) begin
          ctrl_ff[c][BIT_TEND] <= 1'b1;
        end
        if (i_reg_rd && reg_hit && reg_ch == 2'(c) && reg_off == OFF_CONTROL &&
            ctrl_ff[c][BIT_TEND]) begin
          tend_seen_ff[c] <= 1'b1;
        end else if (!ctrl_ff[c][BIT_TEND]) begin
          tend_seen_ff[c] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 32'h00000000;
    end else if (i_clk_en && i_reg_rd) begin
      if (!reg_hit) begin
        o_reg_rdata <= 32'h00000000;
      end else if (reg_off == OFF_SRC_PTR) begin
        o_reg_rdata <= src_ptr_ff[reg_ch];
      end else if (reg_off == OFF_DST_PTR) begin
        o_reg_rdata <= dst_ptr_ff[reg_ch];
      end else if (reg_off == OFF_COUNT) begin
        o_reg_rdata <= {8'h00, count_ff[reg_ch]};
      end else begin
        o_reg_rdata <= ctrl_ff[reg_ch];
      end
    end
  end

  // ----------------------------------------------------------------
  // Request pins
  // ----------------------------------------------------------------
  // A level counts only once the last two stages agree, which filters
  // a pin that is still settling.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      req_s1_ff   <= 2'b11;
      req_s2_ff   <= 2'b11;
      req_s3_ff   <= 2'b11;
      req_lvl_ff  <= 2'b11;
      req_edge_ff <= 2'b00;
    end else if (i_clk_en) begin
      req_s1_ff <= i_transfer_request_in_n;
      req_s2_ff <= req_s1_ff;
      req_s3_ff <= req_s2_ff;
      for (int c = 0; c < 2; c++) begin
        if (req_s2_ff[c] == req_s3_ff[c]) req_lvl_ff[c] <= req_s3_ff[c];
        if (req_s2_ff[c] == req_s3_ff[c] && !req_s3_ff[c] && req_lvl_ff[c]) begin
          req_edge_ff[c] <= 1'b1;
        end else if (eng_ff == ENG_IDLE && nxt_eng == ENG_READ && nxt_ch == 2'(c)) begin
          req_edge_ff[c] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      ext_req[c] = ctrl_ff[c][BIT_REQ_SENSE] ? req_edge_ff[c] : !req_lvl_ff[c];
    end
    for (int c = 0; c < 4; c++) begin
      eligible[c] = ctrl_ff[c][BIT_RUN] && !ctrl_ff[c][BIT_TEND] &&
                    (ctrl_ff[c][POS_REQ_SRC +: 4] == REQ_AUTO ||
                     (c < 2 && is_ext(ctrl_ff[c][POS_REQ_SRC +: 4]) && ext_req[c % 2]));
    end
  end

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  // A unit is read into the FIFO, then written out; the read is not
  // started while the FIFO is full, so a stalled write holds the source.
  always_comb begin
    nxt_eng = eng_ff;
    nxt_ch  = act_ch_ff;
    case (eng_ff)
      ENG_IDLE: begin
        if (fifo_in_ready && |eligible) begin
          nxt_eng = ENG_READ;
          nxt_ch  = eligible[0] ? 2'd0 : eligible[1] ? 2'd1 : eligible[2] ? 2'd2 : 2'd3;
        end
      end
      ENG_READ: begin
        if (i_bus_ack) nxt_eng = ENG_XFER;
      end
      ENG_XFER: begin
        if (fifo_out_valid) nxt_eng = ENG_WRITE;
      end
      default: begin
        if (i_bus_ack) nxt_eng = ENG_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      eng_ff    <= ENG_IDLE;
      act_ch_ff <= 2'd0;
    end else if (i_clk_en) begin
      eng_ff    <= nxt_eng;
      act_ch_ff <= nxt_ch;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_bus_addr  <= 32'h00000000;
      o_bus_rd    <= 1'b0;
      o_bus_wr    <= 1'b0;
      o_bus_size  <= 2'h0;
      o_bus_wdata <= 32'h00000000;
    end else if (i_clk_en) begin
      o_bus_rd   <= nxt_eng == ENG_READ;
      o_bus_wr   <= nxt_eng == ENG_WRITE;
      o_bus_addr <= nxt_eng == ENG_WRITE ? dst_ptr_ff[nxt_ch] : src_ptr_ff[nxt_ch];
      o_bus_size <= ctrl_ff[nxt_ch][POS_UNIT_SIZE +: 2];
      if (eng_ff == ENG_XFER && fifo_out_valid) o_bus_wdata <= fifo_out_data;
    end
  end

  // ----------------------------------------------------------------
  // Acknowledge and request-accepted pins
  // ----------------------------------------------------------------
  // Both pins idle at the inverse of their polarity bit, so a reset
  // control register leaves them high (active-low idle).
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_transfer_ack_strobe <= 2'b11;
      o_request_accept_out  <= 2'b11;
    end else if (i_clk_en) begin
      for (int c = 0; c < 2; c++) begin
        if (nxt_ch == 2'(c) && is_ext(ctrl_ff[c][POS_REQ_SRC +: 4]) &&
            ((nxt_eng == ENG_READ && (is_single(ctrl_ff[c][POS_REQ_SRC +: 4]) ||
                                      !ctrl_ff[c][BIT_ACK_CYCLE])) ||
             (nxt_eng == ENG_WRITE && (is_single(ctrl_ff[c][POS_REQ_SRC +: 4]) ||
                                       ctrl_ff[c][BIT_ACK_CYCLE])))) begin
          o_transfer_ack_strobe[c] <= ctrl_ff[c][BIT_ACK_POL];
        end else begin
          o_transfer_ack_strobe[c] <= !ctrl_ff[c][BIT_ACK_POL];
        end
        if (nxt_ch == 2'(c) && nxt_eng != ENG_IDLE &&
            is_ext(ctrl_ff[c][POS_REQ_SRC +: 4])) begin
          o_request_accept_out[c] <= ctrl_ff[c][BIT_REQ_POL];
        end else begin
          o_request_accept_out[c] <= !ctrl_ff[c][BIT_REQ_POL];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------
  ptr_step u_src_step (
    .i_ptr  (src_ptr_ff[act_ch_ff]),
    .i_mode (ctrl_ff[act_ch_ff][POS_SRC_STEP +: 2]),
    .i_size (ctrl_ff[act_ch_ff][POS_UNIT_SIZE +: 2]),
    .o_next (src_next)
  );

  ptr_step u_dst_step (
    .i_ptr  (dst_ptr_ff[act_ch_ff]),
    .i_mode (ctrl_ff[act_ch_ff][POS_DST_STEP +: 2]),
    .i_size (ctrl_ff[act_ch_ff][POS_UNIT_SIZE +: 2]),
    .o_next (dst_next)
  );

  data_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_sys_rst   (i_sys_rst),
    .i_clk_en    (i_clk_en),
    .i_in_valid  (eng_ff == ENG_READ && i_bus_ack),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (i_bus_rdata),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (eng_ff == ENG_XFER),
    .o_out_data  (fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_src_advance: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (unit_done && !reg_write) |=> src_ptr_ff[act_ch_ff] == $past(src_next))
    else $error("source pointer did not advance");
  chk_dst_advance: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (unit_done && !reg_write) |=> dst_ptr_ff[act_ch_ff] == $past(dst_next))
    else $error("destination pointer did not advance");
  chk_count_step: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (unit_done && !reg_write) |=>
      count_ff[act_ch_ff] == 24'($past(count_ff[act_ch_ff]) - COUNT_ONE))
    else $error("count did not drop with the unit");
  chk_count_upper: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_clk_en && i_reg_rd && reg_hit && reg_off == OFF_COUNT) |=> o_reg_rdata[31:24] == 8'h00)
    else $error("count upper bits not zero");
  chk_ctrl_reset: assert property (@(posedge i_ref_clk)
    i_sys_rst |=> ctrl_ff[0] == CTRL_RESET && ctrl_ff[3] == CTRL_RESET)
    else $error("control register not cleared by reset");
  chk_chan_bits: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (ctrl_ff[0][31:19] | ctrl_ff[1][31:19] | ctrl_ff[2][31:20] | ctrl_ff[2][18:16] |
     {ctrl_ff[3][31:21], ctrl_ff[3][19:16]}) == '0)
    else $error("unimplemented control bit set");
  chk_accept_pol: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_clk_en && nxt_eng == ENG_IDLE && !reg_write) |=>
      o_request_accept_out[0] == !ctrl_ff[0][BIT_REQ_POL])
    else $error("request accept idle level wrong");
  chk_single_ack: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_clk_en && nxt_ch == 2'd0 && nxt_eng == ENG_WRITE && !reg_write &&
     is_single(ctrl_ff[0][POS_REQ_SRC +: 4])) |=>
      o_transfer_ack_strobe[0] == ctrl_ff[0][BIT_ACK_POL])
    else $error("acknowledge missing in single address write");
  chk_tend_set: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (unit_done && count_ff[act_ch_ff] == COUNT_ONE) |=> ctrl_ff[act_ch_ff][BIT_TEND])
    else $error("transfer end flag not set");
  chk_tend_noset: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (reg_write && reg_off == OFF_CONTROL && !unit_done && !ctrl_ff[reg_ch][BIT_TEND])
      |=> !ctrl_ff[$past(reg_ch)][BIT_TEND])
    else $error("software set the transfer end flag");

  cov_unit: cover property (@(posedge i_ref_clk) unit_done);
  cov_last: cover property (@(posedge i_ref_clk) unit_done && count_ff[act_ch_ff] == COUNT_ONE);
  cov_full: cover property (@(posedge i_ref_clk) eng_ff == ENG_IDLE && !fifo_in_ready);

endmodule : dma_chan_regs

//--- bus_mem.sv
`timescale 1ns/1ns
module bus_mem (
  // Clock and bus requests
  input  wire logic        i_ref_clk,
  input  wire logic        i_bus_rd,
  input  wire logic        i_bus_wr,
  input  wire logic [31:0] i_bus_addr,
  input  wire logic [31:0] i_bus_wdata,
  // Answers and last write seen
  output logic      [31:0] o_bus_rdata,
  output logic             o_bus_ack,
  output logic      [31:0] o_last_addr,
  output logic      [31:0] o_last_data
);
  // Read data flips outside the answer cycle, so a late sample shows garbage.
  initial o_bus_ack = 1'b0;
  initial o_bus_rdata = 32'h00000000;
  always @(posedge i_ref_clk) begin
    o_bus_ack   <= (i_bus_rd | i_bus_wr) & ~o_bus_ack;
    o_bus_rdata <= (i_bus_rd & ~o_bus_ack) ? ~i_bus_addr : ~o_bus_rdata;
    if (i_bus_wr & ~o_bus_ack) begin
      o_last_addr <= i_bus_addr;
      o_last_data <= i_bus_wdata;
    end
  end
endmodule : bus_mem

//--- tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import dma_chan_pkg::*;
  logic        i_ref_clk, i_sys_rst, i_clk_en, i_reg_rd, i_reg_wr, o_bus_rd, o_bus_wr;
  logic        i_bus_ack;
  logic [1:0]  o_ack, o_acc, o_bus_size;
  logic [1:0]  req_n;
  logic [31:0] i_reg_addr, i_reg_wdata, o_reg_rdata, o_bus_addr, o_bus_wdata;
  logic [31:0] i_bus_rdata, last_a, last_d, d;
  int          fail_count, check_count;
  initial i_ref_clk = 1'b0;
  always #20 i_ref_clk = ~i_ref_clk;
  dma_chan_regs dut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
    .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr), .i_reg_be(4'hf),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_transfer_request_in_n(req_n),
    .o_transfer_ack_strobe(o_ack), .o_request_accept_out(o_acc), .o_bus_addr(o_bus_addr),
    .o_bus_rd(o_bus_rd), .o_bus_wr(o_bus_wr), .o_bus_size(o_bus_size),
    .o_bus_wdata(o_bus_wdata), .i_bus_rdata(i_bus_rdata), .i_bus_ack(i_bus_ack));
  bus_mem mem (.i_ref_clk(i_ref_clk), .i_bus_rd(o_bus_rd), .i_bus_wr(o_bus_wr),
    .i_bus_addr(o_bus_addr), .i_bus_wdata(o_bus_wdata), .o_bus_rdata(i_bus_rdata),
    .o_bus_ack(i_bus_ack), .o_last_addr(last_a), .o_last_data(last_d));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [31:0] ra(input int ch, input logic [3:0] off);
    return 32'h04000020 + 32'(ch * 16) + {28'h0000000, off};
  endfunction : ra
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(negedge i_ref_clk);
    i_reg_addr = a;
    i_reg_wdata = v;
    i_reg_wr = 1'b1;
    @(negedge i_ref_clk);
    i_reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a);
    @(negedge i_ref_clk);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(negedge i_ref_clk);
    i_reg_rd = 1'b0;
    d = o_reg_rdata;
  endtask : rd
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    for (int ch = 0; ch < 4; ch++) begin
      rd(ra(ch, OFF_CONTROL));
      chk(d, 32'h00000000);
    end
    chk({30'h0, o_ack}, 32'h00000003);
    chk({30'h0, o_acc}, 32'h00000003);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_masks;
    logic [31:0] exp [4] = '{32'h0007ff65, 32'h0007ff65, 32'h0008ff25, 32'h0010ff25};
    for (int ch = 0; ch < 4; ch++) begin
      wr(ra(ch, OFF_CONTROL), 32'hffffffe7);
      rd(ra(ch, OFF_CONTROL));
      chk(d, exp[ch]);
      wr(ra(ch, OFF_CONTROL), 32'h00000000);
    end
    wr(ra(1, OFF_COUNT), 32'hffffffff);
    rd(ra(1, OFF_COUNT));
    chk(d, 32'h00ffffff);
    wr(32'h04000060, 32'hffffffff);
    rd(32'h04000060);
    chk(d, 32'h00000000);
    $display("t_masks done");
  endtask : t_masks
  task automatic t_xfer;
    wr(ra(1, OFF_SRC_PTR), 32'h00000100);
    wr(ra(1, OFF_DST_PTR), 32'h00000200);
    wr(ra(1, OFF_COUNT), 32'h00000002);
    wr(ra(1, OFF_CONTROL), 32'h00005411);
    d = 32'h0;
    for (int i = 0; i < 200 && !d[1]; i++) rd(ra(1, OFF_CONTROL));
    if (d[1] !== 1'b1) begin
      fail_count++;
      close_out();
    end
    rd(ra(1, OFF_SRC_PTR));
    chk(d, 32'h00000108);
    rd(ra(1, OFF_DST_PTR));
    chk(d, 32'h00000208);
    rd(ra(1, OFF_COUNT));
    chk(d, 32'h00000000);
    chk(last_a, 32'h00000204);
    chk(last_d, ~32'h00000104);
    wr(ra(1, OFF_CONTROL), 32'h00005412);
    rd(ra(1, OFF_CONTROL));
    chk(d, 32'h00005412);
    wr(ra(1, OFF_CONTROL), 32'h00005410);
    rd(ra(1, OFF_CONTROL));
    chk(d, 32'h00005410);
    $display("t_xfer done");
  endtask : t_xfer
  task automatic t_standby;
    i_clk_en = 1'b0;
    wr(ra(1, OFF_CONTROL), 32'h00000000);
    wr(ra(1, OFF_SRC_PTR), 32'h00000000);
    i_clk_en = 1'b1;
    rd(ra(1, OFF_CONTROL));
    chk(d, 32'h00005410);
    rd(ra(1, OFF_SRC_PTR));
    chk(d, 32'h00000108);
    $display("t_standby done");
  endtask : t_standby
  // One externally requested unit on channel 0 with both pins set active high.
  task automatic t_ext(input logic [31:0] ctl, input logic ack_wr, input logic [31:0] src_end);
    req_n = 2'h2;
    wr(ra(0, OFF_SRC_PTR), 32'h00000300);
    wr(ra(0, OFF_DST_PTR), 32'h00000400);
    wr(ra(0, OFF_COUNT), 32'h00000001);
    wr(ra(0, OFF_CONTROL), ctl);
    for (int i = 0; i < 40 && !o_bus_wr; i++) begin
      @(negedge i_ref_clk);
      if (o_bus_rd) chk({30'h0, o_ack[0], o_acc[0]}, 32'h00000003);
    end
    chk({27'h0, o_bus_size, o_bus_wr, o_ack[0], o_acc[0]},
        {27'h0, ctl[4:3], 1'b1, ack_wr, 1'b1});
    chk(o_bus_addr, 32'h00000400);
    req_n = 2'h3;
    d = 32'h0;
    for (int i = 0; i < 20 && !d[1]; i++) rd(ra(0, OFF_CONTROL));
    chk({29'h0, d[1], o_ack[0], o_acc[0]}, 32'h00000004);
    rd(ra(0, OFF_SRC_PTR));
    chk(d, src_end);
    wr(ra(0, OFF_CONTROL), 32'h00000000);
    $display("t_ext done");
  endtask : t_ext
  initial begin
    {i_reg_rd, i_reg_wr, i_reg_addr, i_reg_wdata} = '0;
    i_clk_en = 1'b1;
    req_n = 2'h3;
    i_sys_rst = 1'b1;
    repeat (6) @(negedge i_ref_clk);
    i_sys_rst = 1'b0;
    t_reset();
    t_masks();
    t_xfer();
    t_standby();
    t_ext(32'h00055011, 1'b0, 32'h00000304);
    t_ext(32'h00055219, 1'b1, 32'h00000310);
    close_out();
  end
endmodule : tb_top
